// ==== odt_decoder.sv ====
// Instruction byte collector and decoder for transfer and arithmetic opcodes.
`timescale 1ns/1ps

// What this block does
// (RULE1) Opening byte 11010111 alone is a complete table translate into the low accumulator byte.
// (RULE2) 11000101 then one addressing byte loads a far pointer into a register and data segment.
// (RULE3) 11000100 then one addressing byte loads a far pointer into a register and extra segment.
// (RULE4) Single byte 00100111 is the packed decimal fix after addition.
// (RULE5) Single byte 00110111 is the unpacked decimal fix after addition.
// (RULE6) Opening byte 000110dw plus one addressing byte is subtract with borrow, register form.
// (RULE7) Add with carry: register, accumulator, immediate (middle 010, 2 data bytes if s:w=01).
// (RULE8) Bit w set means word operand, bit d set means the register field is the destination.
module odt_decoder
  import odt_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  byte_i,
  input  wire logic        byte_valid_i,
  output logic             instr_valid_o,
  output odt_op_t          op_o,
  output logic             word_op_o,
  output logic             reg_is_dest_o,
  output logic             has_modrm_o,
  output logic [1:0]       mod_o,
  output logic [2:0]       reg_o,
  output logic [2:0]       rm_o,
  output logic [15:0]      imm_o
);

  // ****************************************************************
  // Held bytes and sequencing state
  // ****************************************************************
  odt_state_t state_r;
  odt_state_t state_nxt;
  logic [7:0] opc_r;
  logic [7:0] modrm_r;
  logic [7:0] lo_r;
  logic       need_hi_r;
  logic       need_hi_nxt;

  logic [7:0] cur_opc;
  logic [7:0] cur_modrm;
  logic [7:0] cur_lo;
  odt_op_t    cls_op;
  logic       cls_modrm;
  logic       cls_group;
  logic       cls_acc;

  assign cur_opc   = (state_r == ODT_ST_OPCODE) ? byte_i : opc_r;
  assign cur_modrm = (state_r == ODT_ST_MODRM) ? byte_i : modrm_r;
  assign cur_lo    = (state_r == ODT_ST_DATA_LO) ? byte_i : lo_r;

  odt_classify u_classify (
    .opc_i         (cur_opc),
    .op_o          (cls_op),
    .needs_modrm_o (cls_modrm),
    .imm_group_o   (cls_group),
    .acc_form_o    (cls_acc)
  );

  // ****************************************************************
  // Next state and completion
  // ****************************************************************
  logic       finish;
  odt_op_t    fin_op;
  logic [15:0] fin_imm;

  always_comb
  begin
    state_nxt   = state_r;
    need_hi_nxt = need_hi_r;
    finish      = 1'b0;
    if (byte_valid_i)
    begin
      case (state_r)
        ODT_ST_OPCODE:
        begin
          if (cls_modrm)
          begin
            state_nxt = ODT_ST_MODRM;
          end
          else if (cls_acc)
          begin
            state_nxt   = ODT_ST_DATA_LO;
            need_hi_nxt = cur_opc[ODT_POS_W];
          end
          else
          begin
            finish = 1'b1; // (RULE1) (RULE4) (RULE5)
          end
        end
        ODT_ST_MODRM:
        begin
          if (cls_group)
          begin
            state_nxt   = ODT_ST_DATA_LO;
            need_hi_nxt = (cur_opc[1:0] == ODT_SW_TWO_BYTES); // (RULE7)
          end
          else
          begin
            state_nxt = ODT_ST_OPCODE;
            finish    = 1'b1; // (RULE2) (RULE3) (RULE6)
          end
        end
        ODT_ST_DATA_LO:
        begin
          if (need_hi_r)
          begin
            state_nxt = ODT_ST_DATA_HI;
          end
          else
          begin
            state_nxt = ODT_ST_OPCODE;
            finish    = 1'b1;
          end
        end
        ODT_ST_DATA_HI:
        begin
          state_nxt = ODT_ST_OPCODE;
          finish    = 1'b1;
        end
        default:
        begin
          state_nxt = ODT_ST_OPCODE;
        end
      endcase
    end
  end

  always_comb
  begin
    fin_op = cls_op;
    if (cls_group)
    begin
      if (cur_modrm[ODT_POS_REG_LO +: 3] == ODT_MID_ADC)
      begin
        fin_op = ODT_OP_ADC_IMM; // (RULE7)
      end
      else if (cur_modrm[ODT_POS_REG_LO +: 3] == ODT_MID_SBB)
      begin
        fin_op = ODT_OP_SUBTRACT_WITH_BORROW_IMM;
      end
      else
      begin
        fin_op = ODT_OP_UNSUPPORTED;
      end
    end
    if (state_r == ODT_ST_DATA_HI)
    begin
      fin_imm = {byte_i, lo_r};
    end
    else if (state_r == ODT_ST_DATA_LO && cls_group && cur_opc[1:0] == ODT_SW_SIGN_EXT)
    begin
      fin_imm = {{8{cur_lo[7]}}, cur_lo};
    end
    else if (state_r == ODT_ST_DATA_LO)
    begin
      fin_imm = {8'h00, cur_lo};
    end
    else
    begin
      fin_imm = ODT_RST_IMM;
    end
  end

  // ****************************************************************
  // Sequencing registers
  // ****************************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      state_r   <= ODT_ST_OPCODE;
      need_hi_r <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      need_hi_r <= need_hi_nxt;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      opc_r   <= ODT_RST_BYTE;
      modrm_r <= ODT_RST_BYTE;
      lo_r    <= ODT_RST_BYTE;
    end
    else if (byte_valid_i)
    begin
      if (state_r == ODT_ST_OPCODE)
      begin
        opc_r <= byte_i;
      end
      if (state_r == ODT_ST_MODRM)
      begin
        modrm_r <= byte_i;
      end
      if (state_r == ODT_ST_DATA_LO)
      begin
        lo_r <= byte_i;
      end
    end
  end

  // ****************************************************************
  // Decoded instruction outputs
  // ****************************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      instr_valid_o <= 1'b0;
      op_o          <= ODT_OP_NONE;
      word_op_o     <= 1'b0;
      reg_is_dest_o <= 1'b0;
      has_modrm_o   <= 1'b0;
      mod_o         <= 2'h0;
      reg_o         <= 3'h0;
      rm_o          <= 3'h0;
      imm_o         <= ODT_RST_IMM;
    end
    else
    begin
      instr_valid_o <= finish;
      if (finish)
      begin
        op_o          <= fin_op;
        word_op_o     <= cls_op != ODT_OP_UNSUPPORTED && cur_opc[ODT_POS_W]; // (RULE8)
        reg_is_dest_o <= cls_modrm && !cls_group && cur_opc[ODT_POS_D]; // (RULE8)
        has_modrm_o   <= cls_modrm;
        mod_o         <= cls_modrm ? cur_modrm[ODT_POS_MOD_LO +: 2] : 2'h0;
        reg_o         <= cls_modrm ? cur_modrm[ODT_POS_REG_LO +: 3] : 3'h0;
        rm_o          <= cls_modrm ? cur_modrm[ODT_POS_RM_LO +: 3] : 3'h0;
        imm_o         <= fin_imm;
      end
    end
  end

endmodule : odt_decoder

// ==== odt_pkg.sv ====
// Package holding opcode patterns, field positions, reset values and types of the decoder.
package odt_pkg;

  // ****************************************************************
  // Opening byte patterns
  // ****************************************************************
  localparam logic [7:0] ODT_OPC_TABLE_XLATE  = 8'hD7;
  localparam logic [7:0] ODT_OPC_FAR_DATA_SEG = 8'hC5;
  localparam logic [7:0] ODT_OPC_FAR_XTRA_SEG = 8'hC4;
  localparam logic [7:0] ODT_OPC_PACKED_FIX   = 8'h27;
  localparam logic [7:0] ODT_OPC_UNPACKED_FIX = 8'h37;

  // Upper six bits of the register forms (low bits are d and w).
  localparam logic [5:0] ODT_TOP_ADC_REG      = 6'h04;
  localparam logic [5:0] ODT_TOP_SBB_REG      = 6'h06;
  // Upper six bits of the immediate group (low bits are s and w).
  localparam logic [5:0] ODT_TOP_IMM_GROUP    = 6'h20;
  // Upper seven bits of the accumulator forms (low bit is w).
  localparam logic [6:0] ODT_TOP_ADC_ACC      = 7'h0A;
  localparam logic [6:0] ODT_TOP_SBB_ACC      = 7'h0E;

  // Middle field of the addressing byte in the immediate group.
  localparam logic [2:0] ODT_MID_ADC          = 3'h2;
  localparam logic [2:0] ODT_MID_SBB          = 3'h3;
  // Value of s:w that fetches a second data byte.
  localparam logic [1:0] ODT_SW_TWO_BYTES     = 2'h1;
  // Value of s:w that sign-extends a single data byte to a word.
  localparam logic [1:0] ODT_SW_SIGN_EXT      = 2'h3;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ODT_POS_W      = 0;
  localparam int ODT_POS_D      = 1;
  localparam int ODT_POS_RM_LO  = 0;
  localparam int ODT_POS_REG_LO = 3;
  localparam int ODT_POS_MOD_LO = 6;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  ODT_RST_BYTE = 8'h00;
  localparam logic [15:0] ODT_RST_IMM  = 16'h0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    ODT_OP_NONE,
    ODT_OP_BYTE_TABLE_TRANSLATE,
    ODT_OP_LOAD_FAR_POINTER_DATA_SEG,
    ODT_OP_LOAD_FAR_POINTER_EXTRA_SEG,
    ODT_OP_PACKED_DECIMAL_ADD_FIX,
    ODT_OP_UNPACKED_DECIMAL_ADD_FIX,
    ODT_OP_ADC_REG,
    ODT_OP_ADC_IMM,
    ODT_OP_ADC_ACC,
    ODT_OP_SUBTRACT_WITH_BORROW_REG,
    ODT_OP_SUBTRACT_WITH_BORROW_IMM,
    ODT_OP_SUBTRACT_WITH_BORROW_ACC,
    ODT_OP_UNSUPPORTED
  } odt_op_t;

  typedef enum logic [1:0] {
    ODT_ST_OPCODE,
    ODT_ST_MODRM,
    ODT_ST_DATA_LO,
    ODT_ST_DATA_HI
  } odt_state_t;

endpackage : odt_pkg

// ==== odt_classify.sv ====
// Combinational classifier of an opening instruction byte.
`timescale 1ns/1ps

module odt_classify
  import odt_pkg::*;
(
  input  wire logic [7:0] opc_i,
  output odt_op_t         op_o,
  output logic            needs_modrm_o,
  output logic            imm_group_o,
  output logic            acc_form_o
);

  always_comb
  begin
    op_o          = ODT_OP_UNSUPPORTED;
    needs_modrm_o = 1'b0;
    imm_group_o   = 1'b0;
    acc_form_o    = 1'b0;
    if (opc_i == ODT_OPC_TABLE_XLATE)
    begin
      op_o = ODT_OP_BYTE_TABLE_TRANSLATE; // (RULE1)
    end
    else if (opc_i == ODT_OPC_FAR_DATA_SEG)
    begin
      op_o          = ODT_OP_LOAD_FAR_POINTER_DATA_SEG; // (RULE2)
      needs_modrm_o = 1'b1;
    end
    else if (opc_i == ODT_OPC_FAR_XTRA_SEG)
    begin
      op_o          = ODT_OP_LOAD_FAR_POINTER_EXTRA_SEG; // (RULE3)
      needs_modrm_o = 1'b1;
    end
    else if (opc_i == ODT_OPC_PACKED_FIX)
    begin
      op_o = ODT_OP_PACKED_DECIMAL_ADD_FIX; // (RULE4)
    end
    else if (opc_i == ODT_OPC_UNPACKED_FIX)
    begin
      op_o = ODT_OP_UNPACKED_DECIMAL_ADD_FIX; // (RULE5)
    end
    else if (opc_i[7:2] == ODT_TOP_SBB_REG)
    begin
      op_o          = ODT_OP_SUBTRACT_WITH_BORROW_REG; // (RULE6)
      needs_modrm_o = 1'b1;
    end
    else if (opc_i[7:2] == ODT_TOP_ADC_REG)
    begin
      op_o          = ODT_OP_ADC_REG; // (RULE7)
      needs_modrm_o = 1'b1;
    end
    else if (opc_i[7:1] == ODT_TOP_ADC_ACC)
    begin
      op_o       = ODT_OP_ADC_ACC; // (RULE7)
      acc_form_o = 1'b1;
    end
    else if (opc_i[7:1] == ODT_TOP_SBB_ACC)
    begin
      op_o       = ODT_OP_SUBTRACT_WITH_BORROW_ACC;
      acc_form_o = 1'b1;
    end
    else if (opc_i[7:2] == ODT_TOP_IMM_GROUP)
    begin
      op_o          = ODT_OP_ADC_IMM; // (RULE7)
      needs_modrm_o = 1'b1;
      imm_group_o   = 1'b1;
    end
  end

endmodule : odt_classify

// ==== odt_chk_properties.sv ====
// Checker of the decoder outputs against the instruction bytes that caused them.
`timescale 1ns/1ps
module odt_chk
  import odt_pkg::*;
(
  input logic        ref_clk_i,
  input logic        reset_n_i,
  input logic [7:0]  byte_i,
  input logic        byte_valid_i,
  input logic        instr_valid_o,
  input odt_op_t     op_o,
  input logic        word_op_o,
  input logic        reg_is_dest_o,
  input logic        has_modrm_o,
  input logic [1:0]  mod_o,
  input logic [2:0]  reg_o,
  input logic [2:0]  rm_o,
  input logic [15:0] imm_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire       pulse = instr_valid_o;
  wire [7:0] fld   = {mod_o, reg_o, rm_o};

  xlate_op_a: assert property (pulse && op_o == ODT_OP_BYTE_TABLE_TRANSLATE |->
    $past(byte_valid_i && byte_i == ODT_OPC_TABLE_XLATE) && !has_modrm_o) else $error("xlate");
  far_data_a: assert property (pulse && op_o == ODT_OP_LOAD_FAR_POINTER_DATA_SEG |->
    has_modrm_o && fld == $past(byte_i) && word_op_o) else $error("far data");
  far_extra_a: assert property (pulse && op_o == ODT_OP_LOAD_FAR_POINTER_EXTRA_SEG |->
    has_modrm_o && !word_op_o && imm_o == 16'h0000) else $error("far extra");
  packed_fix_a: assert property (pulse && op_o == ODT_OP_PACKED_DECIMAL_ADD_FIX |->
    $past(byte_i) == ODT_OPC_PACKED_FIX && !has_modrm_o) else $error("packed");
  unpacked_fix_a: assert property (pulse && op_o == ODT_OP_UNPACKED_DECIMAL_ADD_FIX |->
    $past(byte_i) == ODT_OPC_UNPACKED_FIX && !has_modrm_o) else $error("unpacked");
  sbb_reg_a: assert property (pulse && op_o == ODT_OP_SUBTRACT_WITH_BORROW_REG |->
    has_modrm_o && fld == $past(byte_i) && imm_o == 16'h0000) else $error("sbb reg");
  adc_imm_a: assert property (pulse && op_o == ODT_OP_ADC_IMM |->
    has_modrm_o && reg_o == ODT_MID_ADC) else $error("adc imm");
  acc_word_a: assert property (pulse && op_o == ODT_OP_ADC_ACC && word_op_o |->
    imm_o[15:8] == $past(byte_i) && !has_modrm_o) else $error("acc word");

  cover property (pulse && op_o == ODT_OP_ADC_IMM && word_op_o);
  cover property (pulse ##1 pulse);
  cover property (pulse && op_o == ODT_OP_UNSUPPORTED);
endmodule : odt_chk

// ==== odt_pfq_model.sv ====
// Prefetch queue model that hands instruction bytes to the decoder.
`timescale 1ns/1ps
module odt_pfq_model
(
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       slow_i,
  output logic      [7:0] byte_o,
  output logic            byte_valid_o
);
  logic [7:0] fifo_q[$];
  int         seed = 16848;

  initial
  begin
    byte_o       = 8'h00;
    byte_valid_o = 1'b0;
  end

  // In gaps the data lines invert every cycle, so every second idle cycle shows the last byte again.
  always @(posedge ref_clk_i)
    if (reset_n_i && fifo_q.size() > 0 && (!slow_i || $random(seed) % 3 == 0))
    begin
      byte_valid_o <= 1'b1;
      byte_o       <= fifo_q.pop_front();
    end
    else
    begin
      byte_valid_o <= 1'b0;
      byte_o       <= ~byte_o;
    end
endmodule : odt_pfq_model

// ==== tb_top.sv ====
// Self-checking testbench of the opcode decoder.
`timescale 1ns/1ps
module tb_top import odt_pkg::*;;
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        slow      = 1'b0;
  logic [7:0]  byte_i;
  logic        byte_valid_i, instr_valid_o, word_op_o, reg_is_dest_o, has_modrm_o;
  odt_op_t     op_o;
  logic [1:0]  mod_o;
  logic [2:0]  reg_o, rm_o;
  logic [15:0] imm_o;
  logic [30:0] exp_q[$];
  int          err_count = 0, check_count = 0, seed = 16848;
  wire  [30:0] seen = {op_o, word_op_o, reg_is_dest_o, has_modrm_o, mod_o, reg_o, rm_o, imm_o};

  always #2 ref_clk_i = ~ref_clk_i;

  odt_pfq_model i_odt_pfq_model (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .slow_i(slow),
    .byte_o(byte_i), .byte_valid_o(byte_valid_i));
  odt_decoder i_odt_decoder (.*);

  task automatic cmp_rec(input string name, input logic [30:0] exp, input logic [30:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : cmp_rec

  function automatic int ref_dec(input logic [31:0] q, output logic [30:0] e);
    logic [7:0] o, m, lo, hi;
    odt_op_t    op;
    int         n;
    logic       md, dst;
    {o, m, lo, hi} = q;
    {n, md, dst, e} = {32'd1, 33'h0};
    op = ODT_OP_UNSUPPORTED;
    case (o) inside
      8'hD7: op = ODT_OP_BYTE_TABLE_TRANSLATE;
      8'h27: op = ODT_OP_PACKED_DECIMAL_ADD_FIX;
      8'h37: op = ODT_OP_UNPACKED_DECIMAL_ADD_FIX;
      8'hC5: op = ODT_OP_LOAD_FAR_POINTER_DATA_SEG;
      8'hC4: op = ODT_OP_LOAD_FAR_POINTER_EXTRA_SEG;
      [8'h10:8'h13]: op = ODT_OP_ADC_REG;
      [8'h18:8'h1B]: op = ODT_OP_SUBTRACT_WITH_BORROW_REG;
      8'h14, 8'h15: op = ODT_OP_ADC_ACC;
      8'h1C, 8'h1D: op = ODT_OP_SUBTRACT_WITH_BORROW_ACC;
      [8'h80:8'h83]: op = m[5:3] == 3'h2 ? ODT_OP_ADC_IMM :
                          m[5:3] == 3'h3 ? ODT_OP_SUBTRACT_WITH_BORROW_IMM : ODT_OP_UNSUPPORTED;
      default: ;
    endcase
    if (op inside {ODT_OP_ADC_ACC, ODT_OP_SUBTRACT_WITH_BORROW_ACC})
    begin
      n = 2 + o[0];
      e[15:0] = {o[0] ? lo : 8'h00, m};
    end
    else if (o[7:2] == 6'h20)
    begin
      n = 3 + (o[1:0] == 2'b01);
      e[15:0] = {o[1:0] == 2'b01 ? hi : o[1:0] == 2'b11 ? {8{lo[7]}} : 8'h00, lo};
      md = 1'b1;
    end
    else if (op inside {ODT_OP_LOAD_FAR_POINTER_DATA_SEG, ODT_OP_LOAD_FAR_POINTER_EXTRA_SEG,
                        ODT_OP_ADC_REG, ODT_OP_SUBTRACT_WITH_BORROW_REG})
    begin
      {n, md, dst} = {32'd2, 1'b1, o[1]};
    end
    e[30:16] = {op, (op != ODT_OP_UNSUPPORTED || o[7:2] == 6'h20) && o[0], dst, md, md ? m : 8'h00};
    return n;
  endfunction : ref_dec

  task automatic send(input logic [31:0] q);
    logic [30:0] e;
    int          n;
    n = ref_dec(q, e);
    exp_q.push_back(e);
    for (int i = 0; i < n; i++)
      i_odt_pfq_model.fifo_q.push_back(q[31-8*i -: 8]);
  endtask : send

  function automatic logic [31:0] rand_instr();
    logic [7:0]  tbl[11] = '{8'hD7, 8'h27, 8'h37, 8'hC5, 8'hC4, 8'h10, 8'h18, 8'h14, 8'h1C,
                              8'h80, 8'hF4};
    logic [31:0] r;
    logic [7:0]  o;
    r = $random(seed);
    o = tbl[$unsigned($random(seed)) % 11];
    if (o inside {8'h10, 8'h18, 8'h80})
      o[1:0] = r[1:0];
    if (o inside {8'h14, 8'h1C})
      o[0] = r[0];
    r[13:12] = 2'b01;
    return {o, r[15:8], r[23:16], r[31:24]};
  endfunction : rand_instr

  task automatic drain(input string name);
    for (int i = 0; i < 4000 && exp_q.size() > 0; i++)
      @(posedge ref_clk_i);
    repeat (3) @(posedge ref_clk_i);
    cmp_rec("pending", 31'h0, 31'(exp_q.size()));
    $display("test %s done", name);
  endtask : drain

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  always @(negedge ref_clk_i)
    if (instr_valid_o === 1'b1)
      cmp_rec("decode", exp_q.size() ? exp_q.pop_front() : 31'h7FFF_FFFF, seen);

  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(negedge ref_clk_i);
    cmp_rec("reset", 31'h0, seen);
    send(32'h81D0_3412);
    send(32'h8313_8000);
    send(32'h8259_7F00);
    send(32'h15AA_5500);
    send(32'h1499_0000);
    send(32'hD700_0000);
    send(32'hC51E_0000);
    send(32'hC4C7_0000);
    send(32'h2700_0000);
    send(32'h3700_0000);
    send(32'h1BFF_0000);
    send(32'h1000_0000);
    send(32'hF400_0000);
    send(32'h8138_C1E2);
    drain("corner");
    // A reset in the middle of an instruction drops its bytes; decoding restarts at an opening byte.
    @(negedge ref_clk_i);
    i_odt_pfq_model.fifo_q.push_back(8'h81);
    i_odt_pfq_model.fifo_q.push_back(8'hD0);
    repeat (6) @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(negedge ref_clk_i);
    cmp_rec("reset", 31'h0, seen);
    send(32'hD700_0000);
    drain("reset");
    for (int t = 0; t < 2; t++)
    begin
      slow <= t[0];
      repeat (300) send(rand_instr());
      drain("random");
    end
    test_done();
  end

  initial
  begin
    repeat (30000) @(posedge ref_clk_i);
    err_count++;
    test_done();
  end
endmodule : tb_top

bind odt_decoder odt_chk i_odt_chk (.*);
